// File: logic/sdc_pkg.sv
// Purpose: shared constants and carriers for the steering condition logic
// Assumes: 40 MHz sys_clk, APB register access, one evaluation tick per ms
// Notes: configuration words are 16 bits wide in the low half of each word
package sdc_pkg;
  localparam int SDC_CLK_MHZ = 40;
  localparam int SDC_EVAL_PERIOD_US = 1000;
  localparam int SDC_EVAL_DIV_CYC = SDC_EVAL_PERIOD_US * SDC_CLK_MHZ;
  localparam logic [7:0] SDC_PRESENT_ON = 8'hFF;
  localparam logic [7:0] SDC_PRESENT_OFF = 8'h00;
  localparam logic [7:0] SDC_TYPE_OL_JOY = 8'h00;
  localparam logic [7:0] SDC_TYPE_CL_JOY = 8'h01;
  localparam logic [7:0] SDC_TYPE_MINI = 8'h02;
  localparam logic [7:0] SDC_TYPE_ANA_JOY = 8'h03;
  localparam logic [7:0] SDC_TYPE_EXT_JOY = 8'h14;
  localparam int SDC_NUM_SECTORS = 15;
  localparam int SDC_NUM_LEVELS = 3;
  localparam int SDC_NUM_CFG = 12;
  // Configuration word indices; byte offset is four times the index
  localparam int SDC_IX_SEC_PRESENT = 0;
  localparam int SDC_IX_SEC_TYPE = 1;
  localparam int SDC_IX_MINI_VEL = 2;
  localparam int SDC_IX_FLOW = 3;
  localparam int SDC_IX_STEADY_ERR = 4;
  localparam int SDC_IX_STEADY_TIME = 5;
  localparam int SDC_IX_ENGAGE_ERR = 6;
  localparam int SDC_IX_GD1_PRESENT = 7;
  localparam int SDC_IX_GD2_PRESENT = 8;
  localparam int SDC_IX_MSG_GAP = 9;
  localparam int SDC_IX_DEV_SPEED = 10;
  localparam int SDC_IX_PRG_SPEED = 11;
  localparam logic [11:0] SDC_OFF_ACCESS = 12'h030;
  localparam logic [11:0] SDC_OFF_STATUS = 12'h034;
  localparam logic [11:0] SDC_OFF_SECTOR_SEL = 12'h038;
  localparam logic [11:0] SDC_OFF_SECTOR_SUM = 12'h03C;
  localparam logic [15:0] SDC_CFG_RST [SDC_NUM_CFG] = '{
    16'h0000, 16'h0000, 16'h0010, 16'h0010, 16'h0020, 16'h0064,
    16'h0040, 16'h0000, 16'h0000, 16'h0064, 16'h0032, 16'h0032};
  localparam logic [3:0] SDC_CFG_SECTOR [SDC_NUM_CFG] = '{
    4'h5, 4'h5, 4'hB, 4'hB, 4'hB, 4'hB,
    4'hB, 4'h5, 4'h5, 4'h6, 4'h5, 4'h5};
  typedef enum logic [1:0] {
    SDC_LVL_NONE = 2'h0,
    SDC_LVL_DEALER = 2'h1,
    SDC_LVL_OEM = 2'h3,
    SDC_LVL_TOP = 2'h2
  } sdc_level_e;
  localparam logic [1:0] SDC_CFG_LEVEL [SDC_NUM_CFG] = '{
    2'h3, 2'h3, 2'h1, 2'h1, 2'h3, 2'h3,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
  localparam logic [3:0] SDC_SECTOR_RST = 4'h0;
  typedef struct packed {
    logic panel_enable;
    logic panel_disable;
    logic [1:0] panel_guid_sel;
    logic sec_cl_enable;
    logic sec_cl_active;
    logic normal_op;
    logic off_road_mode;
    logic signed [15:0] flow_cmd;
    logic signed [15:0] mini_velocity;
    logic signed [15:0] cl_error;
    logic signed [15:0] vehicle_speed;
  } sdc_in_s;
  typedef struct packed {
    logic off_road;
    logic program_switch_allowed;
    logic device_switch_allowed;
    logic guidance_inactive;
    logic guidance_ready;
    logic secondary_device_off;
    logic secondary_device_disabled;
    logic secondary_closed_loop_error_ok;
    logic secondary_closed_loop_enabled;
    logic secondary_open_loop_in_use;
  } sdc_cond_s;
endpackage : sdc_pkg

// File: logic/sdc_tick_timer.sv
// Purpose: tick counter restarted by an event, saturating at its top
// Assumes: tick is a one-cycle enable from the evaluation divider
// Notes: restart wins over tick in the same cycle
`timescale 1ns/1ps
module sdc_tick_timer #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  output logic reached,
  output logic expired
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire logic at_top = &count_q;

  assign count_d = restart ? '0 :
                   (tick && !at_top) ? count_q + W'(1) : count_q;
  assign reached = count_q >= limit;
  assign expired = count_q > limit;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : sdc_tick_timer

// File: logic/sdc_condition_logic.sv
// Purpose: steering device selection conditions with APB configuration
// Assumes: message inputs come from decoders on sys_clk, no crossing needed
// Notes: conditions are sampled once per evaluation tick
// Operation
// - Types 0, 3, 20 are open-loop joysticks
// - Joystick latch needs flow once below limit
// - Open-loop in use: present, enabled, latched, flow high
// - Closed-loop enabled: present, enabled, type 1, flag
// - Closed-loop error within engage limit
// - Disabled when absent or panel disables
// - Off needs present and an idle branch
// - Mini wheel idle when velocity within limit
// - Open-loop idle when flow below limit
// - Closed-loop idle after steady time, inactive
// - Guidance ready needs present selected controller
// - Guidance latch set by not-intended command
// - Message gap beyond limit means unavailable
// - Guidance ready needs intended-for-steering commands
// - Guidance inactive when unselected, missing, unintended
// - Device switch only at low speed
// - Program switch only at low speed
// - Off-road needs normal state and mode
// - Parameters grouped into fifteen checksummed sectors
// - Three unlock codes gate parameter writes
`timescale 1ns/1ps
module sdc_condition_logic
  import sdc_pkg::*;
#(
  parameter int EVAL_DIV = SDC_EVAL_DIV_CYC,
  parameter logic [31:0] CODE_DEALER = 32'h0000_1111, // Arbitrary value
  parameter logic [31:0] CODE_OEM = 32'h0000_2222, // Arbitrary value
  parameter logic [31:0] CODE_TOP = 32'h0000_3333 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sdc_in_s sense,
  input wire logic [1:0] guid_cmd_strobe,
  input wire logic [1:0] guid_cmd_intended,
  output sdc_cond_s cond
);
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // Evaluation tick divider
  logic [31:0] div_q;
  logic tick_q;
  wire logic div_end = div_q == 32'(EVAL_DIV - 1);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + 32'h1;
      tick_q <= div_end;
    end
  end

  // APB decode
  wire logic setup = psel && !penable;
  wire logic [3:0] word_ix = paddr[5:2];
  wire logic in_range = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0;
  wire logic is_cfg = in_range && word_ix < 4'(SDC_NUM_CFG);
  wire logic is_access = paddr == SDC_OFF_ACCESS;
  wire logic is_status = paddr == SDC_OFF_STATUS;
  wire logic is_sel = paddr == SDC_OFF_SECTOR_SEL;
  wire logic is_sum = paddr == SDC_OFF_SECTOR_SUM;
  wire logic mapped = is_cfg || is_access || is_status || is_sel || is_sum;
  logic [1:0] level_q;
  logic [1:0] need_level;
  assign need_level = is_cfg ? SDC_CFG_LEVEL[word_ix] : 2'h0;
  // Gray-coded levels are ranked by decoded order
  function automatic logic [1:0] rank(input logic [1:0] lv);
    rank = {lv[1], lv[1] ^ lv[0]};
  endfunction : rank
  wire logic locked = is_cfg && rank(level_q) < rank(need_level);
  wire logic ro_write = pwrite && (is_status || is_sum);
  wire logic bad = !mapped || (pwrite && locked) || ro_write;
  // Writes land only at the edge where the master samples ready high
  wire logic wr_take = psel && penable && pready && pwrite && !bad;

  // Configuration words
  logic [15:0] cfg_q [SDC_NUM_CFG];
  genvar gi;
  for (gi = 0; gi < SDC_NUM_CFG; gi++) begin : g_cfg
    wire logic hit = wr_take && is_cfg && word_ix == 4'(gi);
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        cfg_q[gi] <= SDC_CFG_RST[gi];
      end else if (hit) begin
        cfg_q[gi] <= pwdata[15:0];
      end
    end
  end

  // Unlock: a matching code opens its level, anything else locks again
  logic [1:0] level_d;
  assign level_d = pwdata == CODE_TOP ? SDC_LVL_TOP :
                   pwdata == CODE_OEM ? SDC_LVL_OEM :
                   pwdata == CODE_DEALER ? SDC_LVL_DEALER : SDC_LVL_NONE;
  logic [3:0] sector_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= SDC_LVL_NONE;
      sector_q <= SDC_SECTOR_RST;
    end else begin
      if (wr_take && is_access) begin
        level_q <= level_d;
      end
      if (wr_take && is_sel && pwdata[3:0] < 4'(SDC_NUM_SECTORS)) begin
        sector_q <= pwdata[3:0];
      end
    end
  end

  // Sector checksum over the words that live in the selected sector
  logic [15:0] sector_sum;
  always_comb begin
    sector_sum = 16'h0000;
    for (int i = 0; i < SDC_NUM_CFG; i++) begin
      if (SDC_CFG_SECTOR[i] == sector_q) begin
        sector_sum = sector_sum + cfg_q[i];
      end
    end
  end

  logic [31:0] rd_word;
  assign rd_word = is_cfg ? {16'h0000, cfg_q[word_ix]} :
                   is_access ? {30'h0, level_q} :
                   is_status ? {22'h0, cond} :
                   is_sel ? {28'h0, sector_q} :
                   is_sum ? {16'h0000, sector_sum} : 32'h0;

  // One-cycle answer: ready rises in the first access cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= bad;
        prdata <= pwrite ? 32'h0 : rd_word;
      end
    end
  end

  // Secondary steering device
  wire logic [7:0] sec_present = cfg_q[SDC_IX_SEC_PRESENT][7:0];
  wire logic [7:0] sec_type = cfg_q[SDC_IX_SEC_TYPE][7:0];
  wire logic [15:0] flow_mag = mag(sense.flow_cmd);
  wire logic [15:0] vel_mag = mag(sense.mini_velocity);
  wire logic [15:0] err_mag = mag(sense.cl_error);
  wire logic [15:0] speed_mag = mag(sense.vehicle_speed);
  wire logic sec_on = sec_present == SDC_PRESENT_ON;
  wire logic type_ol = sec_type == SDC_TYPE_OL_JOY ||
                       sec_type == SDC_TYPE_ANA_JOY ||
                       sec_type == SDC_TYPE_EXT_JOY;
  wire logic type_cl = sec_type == SDC_TYPE_CL_JOY;
  wire logic type_mini = sec_type == SDC_TYPE_MINI;
  wire logic flow_low = flow_mag < cfg_q[SDC_IX_FLOW];
  logic joy_latch_q;
  wire logic steady_ok = err_mag < cfg_q[SDC_IX_STEADY_ERR];
  logic steady_reached;

  // Any cycle with the error at or above limit restarts the steady window
  sdc_tick_timer #(.W(16)) u_steady (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick_q),
    .restart(!steady_ok),
    .limit(cfg_q[SDC_IX_STEADY_TIME]),
    .reached(steady_reached),
    .expired()
  );

  wire logic ol_in_use = sec_on && sense.panel_enable && joy_latch_q &&
                         type_ol && !flow_low;
  wire logic cl_enabled = sec_on && sense.panel_enable && type_cl &&
                          sense.sec_cl_enable;
  wire logic cl_err_ok = err_mag <= cfg_q[SDC_IX_ENGAGE_ERR];
  wire logic sec_dis = sec_present == SDC_PRESENT_OFF ||
                       sense.panel_disable;
  wire logic idle_mini = type_mini &&
                         vel_mag <= cfg_q[SDC_IX_MINI_VEL];
  wire logic idle_ol = type_ol && flow_low;
  wire logic idle_cl = type_cl && steady_ok && steady_reached &&
                       !sense.sec_cl_active;
  wire logic sec_off = sec_on &&
                       (idle_mini || idle_ol || idle_cl);

  // Guidance controllers, first one has priority when both are selected
  logic [1:0] gd_seen_q;
  logic [1:0] gd_intent_q;
  logic [1:0] gd_expired;
  logic gd_latch_q;
  wire logic [1:0] gd_sel_pres = {
    cfg_q[SDC_IX_GD2_PRESENT][7:0] == SDC_PRESENT_ON &&
      sense.panel_guid_sel[1],
    cfg_q[SDC_IX_GD1_PRESENT][7:0] == SDC_PRESENT_ON &&
      sense.panel_guid_sel[0]};
  wire logic gd_any = |gd_sel_pres;
  wire logic gd_ix = !gd_sel_pres[0];
  for (gi = 0; gi < 2; gi++) begin : g_guid
    sdc_tick_timer #(.W(16)) u_gap (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tick(tick_q),
      .restart(guid_cmd_strobe[gi]),
      .limit(cfg_q[SDC_IX_MSG_GAP]),
      .reached(),
      .expired(gd_expired[gi])
    );
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        gd_seen_q[gi] <= 1'b0;
        gd_intent_q[gi] <= 1'b0;
      end else if (guid_cmd_strobe[gi]) begin
        gd_seen_q[gi] <= 1'b1;
        gd_intent_q[gi] <= guid_cmd_intended[gi];
      end
    end
  end
  wire logic gd_avail = gd_seen_q[gd_ix] && !gd_expired[gd_ix];
  wire logic gd_intent = gd_intent_q[gd_ix];
  wire logic gd_reset_seen = gd_any && guid_cmd_strobe[gd_ix] &&
                             !guid_cmd_intended[gd_ix];
  wire logic gd_ready = gd_any && gd_latch_q && gd_avail &&
                        gd_intent;
  wire logic gd_inactive = !gd_any || !gd_avail || !gd_intent;

  wire logic dev_sw = speed_mag <= cfg_q[SDC_IX_DEV_SPEED];
  wire logic prg_sw = speed_mag <= cfg_q[SDC_IX_PRG_SPEED];
  wire logic off_rd = sense.normal_op && sense.off_road_mode;

  sdc_cond_s cond_d;
  assign cond_d = '{
    off_road: off_rd,
    program_switch_allowed: prg_sw,
    device_switch_allowed: dev_sw,
    guidance_inactive: gd_inactive,
    guidance_ready: gd_ready,
    secondary_device_off: sec_off,
    secondary_device_disabled: sec_dis,
    secondary_closed_loop_error_ok: cl_err_ok,
    secondary_closed_loop_enabled: cl_enabled,
    secondary_open_loop_in_use: ol_in_use};

  // Latches only set; a guidance marking between ticks is still caught
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      joy_latch_q <= 1'b0;
      gd_latch_q <= 1'b0;
      cond <= '0;
    end else begin
      if (tick_q && type_ol && flow_low) begin
        joy_latch_q <= 1'b1;
      end
      if (gd_reset_seen) begin
        gd_latch_q <= 1'b1;
      end
      if (tick_q) begin
        cond <= cond_d;
      end
    end
  end

  // Checks
  a_cond_on_tick: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(tick_q) |-> $stable(cond))
    else $error("conditions changed without a tick");
  a_cond_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_q |=> cond == $past(cond_d))
    else $error("conditions not sampled on tick");
  a_ol_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ol_in_use |-> joy_latch_q && !flow_low && sec_on)
    else $error("open-loop in use without reset latch");
  a_ol_types: assert property (@(posedge sys_clk) disable iff (!reset_n)
    type_ol |-> sec_type inside {8'h00, 8'h03, 8'h14})
    else $error("wrong open-loop type decode");
  a_dis_absent: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_q && sec_present == 8'h00 |=> cond.secondary_device_disabled)
    else $error("absent device not disabled");
  a_off_present: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_q && !sec_on |=> !cond.secondary_device_off)
    else $error("device off while not present");
  a_gd_excl: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(cond.guidance_ready && cond.guidance_inactive))
    else $error("guidance ready and inactive together");
  a_gd_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    gd_ready |-> gd_latch_q && gd_avail)
    else $error("guidance ready without reset marking");
  a_gap_expire: assert property (@(posedge sys_clk) disable iff (!reset_n)
    guid_cmd_strobe[0] |=> !gd_expired[0])
    else $error("gap timer not restarted by message");
  a_speed_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_q && speed_mag > cfg_q[SDC_IX_DEV_SPEED] |=>
    !cond.device_switch_allowed)
    else $error("device switch allowed above speed");
  a_lock_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    psel && penable && pready && pwrite && locked |->
    pslverr ##1 $stable(cfg_q[$past(word_ix)]))
    else $error("locked write was accepted");
  a_apb_ready: assert property (@(posedge sys_clk) disable iff (!reset_n)
    setup |=> pready)
    else $error("no answer one cycle after setup");
  c_ol_use: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cond.secondary_open_loop_in_use);
  c_gd_ready: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cond.guidance_ready);
  c_cl_off: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cond.secondary_device_off && type_cl);
  c_unlock: cover property (@(posedge sys_clk) disable iff (!reset_n)
    level_q == SDC_LVL_TOP);
endmodule : sdc_condition_logic

// File: dv/sdc_far_side.sv
// Purpose: far-side model sending guidance command markers
// Assumes: one strobe per command, gap given in sys_clk cycles
// Notes: the marking wanders between commands since nothing qualifies it
`timescale 1ns/1ps
module sdc_far_side (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] send_en,
  input wire logic [1:0] intended,
  input wire logic [7:0] gap_cyc,
  output logic [1:0] guid_cmd_strobe,
  output logic [1:0] guid_cmd_intended
);
  logic [7:0] cnt_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      guid_cmd_strobe <= 2'h0;
      guid_cmd_intended <= 2'h0;
    end else if (cnt_q >= gap_cyc) begin
      // Caller keeps the period within the monitored gap
      cnt_q <= 8'h00;
      guid_cmd_strobe <= send_en;
      guid_cmd_intended <= intended;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      guid_cmd_strobe <= 2'h0;
      guid_cmd_intended <= ~guid_cmd_intended;
    end
  end
endmodule : sdc_far_side

// File: dv/testbench.sv
// Purpose: self-checking bench for the steering condition logic
// Assumes: short evaluation tick of 8 cycles, zero-wait APB slave
// Notes: unlock codes are arbitrary values handed to the design
`timescale 1ns/1ps
module testbench;
  import sdc_pkg::*;
  localparam int DIV = 8;
  localparam logic [31:0] K_DLR = 32'h0000_1111; // Arbitrary value
  localparam logic [31:0] K_OEM = 32'h0000_2222; // Arbitrary value
  localparam logic [31:0] K_TOP = 32'h0000_3333; // Arbitrary value
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  sdc_in_s sense = '0;
  logic [1:0] send_en = 2'h0;
  logic [1:0] intended = 2'h0;
  logic [1:0] strobe, intd;
  // Short command period so a new marking lands well inside one settle
  logic [7:0] gap_cyc = 8'h03;
  sdc_cond_s cond;
  logic [15:0] sum;
  logic [7:0] typ [3] = '{SDC_TYPE_OL_JOY, SDC_TYPE_ANA_JOY, SDC_TYPE_EXT_JOY};
  int miscompares = 0;
  int checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  sdc_condition_logic #(.EVAL_DIV(DIV), .CODE_DEALER(K_DLR),
    .CODE_OEM(K_OEM), .CODE_TOP(K_TOP)) i_sdc_condition_logic (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense),
    .guid_cmd_strobe(strobe), .guid_cmd_intended(intd), .cond(cond));
  sdc_far_side i_sdc_far_side (
    .sys_clk(sys_clk), .reset_n(reset_n), .send_en(send_en),
    .intended(intended), .gap_cyc(gap_cyc), .guid_cmd_strobe(strobe),
    .guid_cmd_intended(intd));
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  function automatic logic [11:0] ax(input int i);
    return 12'(4 * i);
  endfunction : ax
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      end_sim();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    apb(1'b1, a, d);
    chk_bit("pslverr", e, err);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word("prdata", e, rd);
    chk_bit("pslverr", 1'b0, err);
  endtask : rdc
  task automatic settle;
    // Covers the worst-case tick latency twice over
    repeat (2 * DIV + 2) @(posedge sys_clk);
  endtask : settle
  initial begin
    sense.flow_cmd = 16'sh0100;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk_word("cond_reset", 32'h0, 32'(cond));
    rdc(ax(SDC_IX_FLOW), 32'(SDC_CFG_RST[SDC_IX_FLOW]));
    wr(ax(SDC_IX_SEC_PRESENT), 32'h00FF, 1'b1);
    wr(SDC_OFF_ACCESS, K_DLR, 1'b0);
    rdc(SDC_OFF_ACCESS, 32'(SDC_LVL_DEALER));
    wr(ax(SDC_IX_MINI_VEL), 32'h0010, 1'b0);
    wr(ax(SDC_IX_SEC_TYPE), 32'h0000, 1'b1);
    wr(SDC_OFF_ACCESS, K_OEM, 1'b0);
    rdc(SDC_OFF_ACCESS, 32'(SDC_LVL_OEM));
    wr(SDC_OFF_STATUS, 32'h0, 1'b1);
    apb(1'b0, 12'h040, 32'h0);
    chk_word("unmapped_data", 32'h0, rd);
    chk_bit("unmapped_err", 1'b1, err);
    for (int s = 0; s < SDC_NUM_SECTORS; s++) begin
      sum = 16'h0000;
      for (int i = 0; i < SDC_NUM_CFG; i++) begin
        if (SDC_CFG_SECTOR[i] == 4'(s)) sum = sum + SDC_CFG_RST[i];
      end
      wr(SDC_OFF_SECTOR_SEL, 32'(s), 1'b0);
      rdc(SDC_OFF_SECTOR_SUM, {16'h0, sum});
    end
    $display("test access done");
    sense.panel_enable <= 1'b1;
    wr(ax(SDC_IX_SEC_PRESENT), 32'h00FF, 1'b0);
    settle;
    chk_bit("ol_unlatched", 1'b0, cond.secondary_open_loop_in_use);
    for (int t = 0; t < 3; t++) begin
      wr(ax(SDC_IX_SEC_TYPE), 32'(typ[t]), 1'b0);
      sense.flow_cmd <= 16'sh000F;
      settle;
      chk_bit("ol_low", 1'b0, cond.secondary_open_loop_in_use);
      chk_bit("off_ol", 1'b1, cond.secondary_device_off);
      sense.flow_cmd <= -16'sh0010;
      settle;
      chk_bit("ol_on", 1'b1, cond.secondary_open_loop_in_use);
      chk_bit("off_ol_hi", 1'b0, cond.secondary_device_off);
    end
    sense.panel_enable <= 1'b0;
    settle;
    chk_bit("ol_noen", 1'b0, cond.secondary_open_loop_in_use);
    sense.panel_enable <= 1'b1;
    wr(ax(SDC_IX_SEC_TYPE), 32'(SDC_TYPE_MINI), 1'b0);
    sense.mini_velocity <= -16'sh0010;
    settle;
    chk_bit("ol_mini", 1'b0, cond.secondary_open_loop_in_use);
    chk_bit("off_mini", 1'b1, cond.secondary_device_off);
    sense.mini_velocity <= 16'sh0011;
    settle;
    chk_bit("off_mini_hi", 1'b0, cond.secondary_device_off);
    $display("test open loop done");
    wr(ax(SDC_IX_STEADY_TIME), 32'h0004, 1'b0);
    wr(ax(SDC_IX_SEC_TYPE), 32'(SDC_TYPE_CL_JOY), 1'b0);
    sense.sec_cl_enable <= 1'b1;
    sense.cl_error <= -16'sh0040;
    settle;
    chk_bit("cl_en", 1'b1, cond.secondary_closed_loop_enabled);
    chk_bit("cl_ok", 1'b1, cond.secondary_closed_loop_error_ok);
    chk_bit("off_cl_err", 1'b0, cond.secondary_device_off);
    sense.cl_error <= 16'sh0041;
    sense.sec_cl_enable <= 1'b0;
    settle;
    chk_bit("cl_en_off", 1'b0, cond.secondary_closed_loop_enabled);
    chk_bit("cl_bad", 1'b0, cond.secondary_closed_loop_error_ok);
    sense.cl_error <= 16'sh001F;
    repeat (2 * DIV) @(posedge sys_clk);
    chk_bit("off_cl_early", 1'b0, cond.secondary_device_off);
    repeat (6 * DIV) @(posedge sys_clk);
    chk_bit("off_cl", 1'b1, cond.secondary_device_off);
    sense.sec_cl_active <= 1'b1;
    settle;
    chk_bit("off_cl_act", 1'b0, cond.secondary_device_off);
    sense.panel_disable <= 1'b1;
    settle;
    chk_bit("dis_panel", 1'b1, cond.secondary_device_disabled);
    sense.panel_disable <= 1'b0;
    settle;
    chk_bit("dis_none", 1'b0, cond.secondary_device_disabled);
    wr(ax(SDC_IX_SEC_PRESENT), 32'h0000, 1'b0);
    settle;
    chk_bit("dis_absent", 1'b1, cond.secondary_device_disabled);
    chk_bit("off_absent", 1'b0, cond.secondary_device_off);
    $display("test closed loop done");
    for (int k = 0; k < 4; k++) begin
      sense.normal_op <= k[0];
      sense.off_road_mode <= k[1];
      sense.vehicle_speed <= k[0] ? 16'sh0033 : -16'sh0032;
      settle;
      chk_bit("off_road", k == 3, cond.off_road);
      chk_bit("dev_sw", !k[0], cond.device_switch_allowed);
      chk_bit("prg_sw", !k[0], cond.program_switch_allowed);
    end
    $display("test speed done");
    wr(ax(SDC_IX_GD1_PRESENT), 32'h00FF, 1'b0);
    wr(ax(SDC_IX_MSG_GAP), 32'h0003, 1'b0);
    sense.panel_guid_sel <= 2'b01;
    send_en <= 2'b01;
    intended <= 2'b01;
    settle;
    chk_bit("gd_nolatch", 1'b0, cond.guidance_ready);
    intended <= 2'b00;
    settle;
    chk_bit("gd_unint", 1'b0, cond.guidance_ready);
    chk_bit("gd_unint_in", 1'b1, cond.guidance_inactive);
    intended <= 2'b01;
    settle;
    chk_bit("gd_ready", 1'b1, cond.guidance_ready);
    chk_bit("gd_active", 1'b0, cond.guidance_inactive);
    sense.panel_guid_sel <= 2'b10;
    settle;
    chk_bit("gd2_absent", 1'b0, cond.guidance_ready);
    chk_bit("gd2_inact", 1'b1, cond.guidance_inactive);
    sense.panel_guid_sel <= 2'b01;
    settle;
    chk_bit("gd_back", 1'b1, cond.guidance_ready);
    send_en <= 2'b00;
    repeat (3) settle;
    chk_bit("gd_gap", 1'b0, cond.guidance_ready);
    chk_bit("gd_gap_in", 1'b1, cond.guidance_inactive);
    $display("test guidance done");
    end_sim();
  end
endmodule : testbench
